//--- common/rfc_pkg.sv
// rfc_pkg: constants shared by the reference frequency configuration bank
// assumes a byte-indexed register map reached over a 32-bit wishbone slave
package rfc_pkg;

    localparam int NUM_REFS_DEFAULT = 4;
    localparam int MAX_REFS         = 4;
    localparam int BYTES_PER_REF    = 8;

    // register indices; byte address on the bus is four times the index
    localparam logic [6:0] IDX_CFG_FIRST              = 7'h10;
    localparam logic [6:0] IDX_INPUT0_BASE_RATE       = 7'h10;
    localparam logic [6:0] IDX_INPUT0_RATE_MULTIPLIER = 7'h12;
    localparam logic [6:0] IDX_INPUT0_FEC_RATIO       = 7'h14;
    localparam logic [6:0] IDX_INPUT1_BASE_RATE       = 7'h18;
    localparam logic [6:0] IDX_INPUT1_RATE_MULTIPLIER = 7'h1A;
    localparam logic [6:0] IDX_INPUT1_FEC_RATIO       = 7'h1C;
    localparam logic [6:0] IDX_INPUT2_BASE_RATE       = 7'h20;
    localparam logic [6:0] IDX_INPUT2_RATE_MULTIPLIER = 7'h22;
    localparam logic [6:0] IDX_INPUT2_FEC_RATIO       = 7'h24;
    localparam logic [6:0] IDX_INPUT3_BASE_RATE       = 7'h28;
    localparam logic [6:0] IDX_INPUT3_RATE_MULTIPLIER = 7'h2A;
    localparam logic [6:0] IDX_INPUT3_FEC_RATIO       = 7'h2C;
    localparam logic [6:0] IDX_STATUS_FIRST           = 7'h40;
    localparam logic [6:0] IDX_FREQ_FIRST             = 7'h44;

    // byte position of each register inside one reference's block
    localparam int OFS_BASE_RATE  = 0;
    localparam int OFS_MULTIPLIER = 2;
    localparam int OFS_FEC_RATIO  = 4;

    // ratio word fields
    localparam int DEN_LSB = 0;
    localparam int NUM_LSB = 16;

    // values after reset
    localparam logic [15:0] RST_BASE_RATE       = 16'h9C40;
    localparam logic [15:0] RST_MULTIPLIER_REF0 = 16'h0F30;
    localparam logic [15:0] RST_MULTIPLIER      = 16'h01E6;
    localparam logic [31:0] RST_FEC_RATIO       = 32'h0001_0001;

    // status byte fields
    localparam int STS_RATE_SUPPORTED = 0;
    localparam int STS_FEC_ACTIVE     = 1;
    localparam int STS_DENOM_ZERO     = 2;
    localparam int STS_HALVING        = 3;
    localparam int STS_FREQ_VALID     = 4;

    localparam int NUM_SUPPORTED = 9;
    localparam logic [15:0] SUPPORTED_RATES [NUM_SUPPORTED] = '{
        16'h03E8, 16'h07D0, 16'h1388, 16'h186A, 16'h1F40,
        16'h2710, 16'h30D4, 16'h61A8, 16'h9C40
    };

    localparam logic [5:0]  DIV_STEPS = 6'h30;
    localparam logic [31:0] FREQ_SATURATED = 32'hFFFF_FFFF;

    typedef enum logic [0:0] {
        RFC_BUS_IDLE = 1'b0,
        RFC_BUS_ACK  = 1'b1
    } rfc_bus_state_t;

    typedef enum logic [1:0] {
        RFC_DIV_PICK  = 2'b00,
        RFC_DIV_RUN   = 2'b01,
        RFC_DIV_STORE = 2'b10
    } rfc_div_state_t;

endpackage

//--- logic/rfc_ref_eval.sv
// rfc_ref_eval: combinational view of one reference's stored settings
// assumes the caller registers whatever it needs from these outputs
`timescale 1ns/1ps
module rfc_ref_eval (
    input  wire logic [15:0] base_rate_i,
    input  wire logic [15:0] multiplier_i,
    input  wire logic [15:0] numerator_i,
    input  wire logic [15:0] denominator_i,
    output logic      [47:0] scaled_product_o,
    output logic             rate_supported_o,
    output logic             fec_active_o,
    output logic             denom_zero_o
);

    // base rate, multiplier and numerator are plain unsigned integers
    always_comb begin
        scaled_product_o = 48'(base_rate_i) * 48'(multiplier_i) * 48'(numerator_i); // R4 R6
        rate_supported_o = 1'b0;
        for (int i = 0; i < rfc_pkg::NUM_SUPPORTED; i++) begin
            if (base_rate_i == rfc_pkg::SUPPORTED_RATES[i]) begin
                rate_supported_o = 1'b1; // R5
            end
        end
        fec_active_o = (numerator_i != denominator_i); // R3
        denom_zero_o = (denominator_i == 16'h0000);
    end

endmodule

//--- logic/rfc_top.sv
// rfc_top: per-input frequency description bank with a wishbone slave,
// plus a background divider that derives each input's nominal frequency
// assumes a classic wishbone master on clk_i and synchronous reset rst_i
`timescale 1ns/1ps
// Function
// R1: ratio word: denominator low half, numerator high
// R2: software makes the product formula equal input frequency
// R3: ordinary inputs keep numerator and denominator at one
// R4: base rate is unsigned hertz
// R5: software uses only the supported base rate values
// R6: multiplier is an unsigned factor of base rate
// R7: multi-byte registers are big-endian across byte addresses
// R8: reset values for base, ratio and multipliers
// R9: each input owns base, multiplier and ratio registers
// R10: with halving enabled, software programs half frequency
// R11: no coupling between different inputs' registers
module rfc_top #(
    parameter int NUM_REFS = rfc_pkg::NUM_REFS_DEFAULT
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [8:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    input  wire logic [NUM_REFS-1:0]    halving_enable_i,
    output logic      [NUM_REFS*16-1:0] base_rate_value_o,
    output logic      [NUM_REFS*16-1:0] base_rate_multiplier_o,
    output logic      [NUM_REFS*16-1:0] fec_numerator_o,
    output logic      [NUM_REFS*16-1:0] fec_denominator_o,
    output logic      [NUM_REFS*32-1:0] ref_frequency_o,
    output logic      [NUM_REFS-1:0]    frequency_valid_o,
    output logic      [NUM_REFS-1:0]    rate_supported_o
);

    localparam int MAP_BYTES = NUM_REFS * rfc_pkg::BYTES_PER_REF;

    if (NUM_REFS < 1 || NUM_REFS > rfc_pkg::MAX_REFS) begin : g_bad_refs
        $error("rfc_top: NUM_REFS must be between 1 and 4");
    end

    // big-endian reset image of one input: base, multiplier, ratio
    function automatic logic [7:0] reset_byte(input int unsigned r, input int unsigned b);
        logic [63:0] img;
        img = {rfc_pkg::RST_BASE_RATE,
               (r == 0) ? rfc_pkg::RST_MULTIPLIER_REF0 : rfc_pkg::RST_MULTIPLIER,
               rfc_pkg::RST_FEC_RATIO}; // R8
        return img[8*(7-b) +: 8]; // R7
    endfunction

    // ---------------- bus decode ----------------
    logic [6:0] idx;
    logic [6:0] cfg_rel;
    logic [6:0] sts_rel;
    logic [6:0] frq_rel;
    logic       hit_cfg;
    logic       hit_sts;
    logic       hit_frq;
    logic       bus_req;

    assign idx     = wb_adr_i[8:2];
    assign cfg_rel = idx - rfc_pkg::IDX_CFG_FIRST;
    assign sts_rel = idx - rfc_pkg::IDX_STATUS_FIRST;
    assign frq_rel = idx - rfc_pkg::IDX_FREQ_FIRST;
    assign hit_cfg = (idx >= rfc_pkg::IDX_CFG_FIRST) && (cfg_rel < 7'(MAP_BYTES));
    assign hit_sts = (idx >= rfc_pkg::IDX_STATUS_FIRST) && (sts_rel < 7'(NUM_REFS));
    assign hit_frq = (idx >= rfc_pkg::IDX_FREQ_FIRST) && (frq_rel < 7'(NUM_REFS * 4));
    assign bus_req = wb_cyc_i & wb_stb_i;

    // ---------------- state ----------------
    rfc_pkg::rfc_bus_state_t bus_state_q;
    rfc_pkg::rfc_bus_state_t bus_state_d;
    logic [7:0]              cfg_q [MAP_BYTES];
    logic [7:0]              cfg_d [MAP_BYTES];
    logic [31:0]             rdata_q;
    logic [31:0]             rdata_d;

    rfc_pkg::rfc_div_state_t div_state_q;
    rfc_pkg::rfc_div_state_t div_state_d;
    logic [1:0]              div_ref_q;
    logic [1:0]              div_ref_d;
    logic [5:0]              div_cnt_q;
    logic [5:0]              div_cnt_d;
    logic [47:0]             dvd_q;
    logic [47:0]             dvd_d;
    logic [16:0]             rem_q;
    logic [16:0]             rem_d;
    logic [15:0]             den_q;
    logic [15:0]             den_d;
    logic [47:0]             quo_q;
    logic [47:0]             quo_d;
    logic [31:0]             freq_q [NUM_REFS];
    logic [31:0]             freq_d [NUM_REFS];
    logic [NUM_REFS-1:0]     valid_q;
    logic [NUM_REFS-1:0]     valid_d;
    logic [NUM_REFS-1:0]     changed_q;
    logic [NUM_REFS-1:0]     changed_d;
    logic [3:0]              flags_q [NUM_REFS];
    logic [3:0]              flags_d [NUM_REFS];

    // a write takes effect at the edge where the master sees ack
    logic       wr_now;
    logic [1:0] wr_ref;

    assign wr_now = (bus_state_q == rfc_pkg::RFC_BUS_ACK) & bus_req & wb_we_i
                    & wb_sel_i[0] & hit_cfg;
    assign wr_ref = cfg_rel[4:3];

    // ---------------- per-input field views ----------------
    logic [15:0] br    [NUM_REFS];
    logic [15:0] kr    [NUM_REFS];
    logic [15:0] mr    [NUM_REFS];
    logic [15:0] nr    [NUM_REFS];
    logic [47:0] prod  [NUM_REFS];
    logic        sup   [NUM_REFS];
    logic        fec   [NUM_REFS];
    logic        dzero [NUM_REFS];

    for (genvar r = 0; r < NUM_REFS; r++) begin : g_ref
        localparam int B = r * rfc_pkg::BYTES_PER_REF;
        logic [31:0] ratio;

        // lower byte address carries the more significant byte
        assign br[r] = {cfg_q[B + rfc_pkg::OFS_BASE_RATE],
                        cfg_q[B + rfc_pkg::OFS_BASE_RATE + 1]}; // R7 R9
        assign kr[r] = {cfg_q[B + rfc_pkg::OFS_MULTIPLIER],
                        cfg_q[B + rfc_pkg::OFS_MULTIPLIER + 1]}; // R7 R9
        assign ratio = {cfg_q[B + rfc_pkg::OFS_FEC_RATIO],
                        cfg_q[B + rfc_pkg::OFS_FEC_RATIO + 1],
                        cfg_q[B + rfc_pkg::OFS_FEC_RATIO + 2],
                        cfg_q[B + rfc_pkg::OFS_FEC_RATIO + 3]}; // R7 R9
        assign mr[r] = ratio[rfc_pkg::NUM_LSB +: 16]; // R1
        assign nr[r] = ratio[rfc_pkg::DEN_LSB +: 16]; // R1

        rfc_ref_eval u_eval (
            .base_rate_i      (br[r]),
            .multiplier_i     (kr[r]),
            .numerator_i      (mr[r]),
            .denominator_i    (nr[r]),
            .scaled_product_o (prod[r]),
            .rate_supported_o (sup[r]),
            .fec_active_o     (fec[r]),
            .denom_zero_o     (dzero[r])
        );

        assign base_rate_value_o[r*16 +: 16]      = br[r];
        assign base_rate_multiplier_o[r*16 +: 16] = kr[r];
        assign fec_numerator_o[r*16 +: 16]        = mr[r];
        assign fec_denominator_o[r*16 +: 16]      = nr[r];
        assign ref_frequency_o[r*32 +: 32]        = freq_q[r];
        assign rate_supported_o[r]                = flags_q[r][rfc_pkg::STS_RATE_SUPPORTED];
    end

    assign frequency_valid_o = valid_q;

    // ---------------- bus and configuration bytes ----------------
    logic [7:0] rd_byte;
    logic [4:0] sts_byte;

    always_comb begin
        rd_byte  = 8'h00;
        sts_byte = 5'h00;
        if (hit_cfg) begin
            rd_byte = cfg_q[cfg_rel[4:0]];
        end else if (hit_sts) begin
            sts_byte = {valid_q[sts_rel[1:0]], flags_q[sts_rel[1:0]]};
            rd_byte  = {3'h0, sts_byte};
        end else if (hit_frq) begin
            rd_byte = freq_q[frq_rel[3:2]][{~frq_rel[1:0], 3'b000} +: 8]; // R7
        end
    end

    always_comb begin
        bus_state_d = bus_state_q;
        rdata_d     = rdata_q;
        cfg_d       = cfg_q;
        if (rst_i) begin
            bus_state_d = rfc_pkg::RFC_BUS_IDLE;
            rdata_d     = 32'h0000_0000;
            for (int i = 0; i < MAP_BYTES; i++) begin
                cfg_d[i] = reset_byte(i / rfc_pkg::BYTES_PER_REF,
                                      i % rfc_pkg::BYTES_PER_REF); // R8
            end
        end else begin
            case (bus_state_q)
                rfc_pkg::RFC_BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state_d = rfc_pkg::RFC_BUS_ACK;
                        rdata_d     = {24'h00_0000, rd_byte};
                    end
                end
                rfc_pkg::RFC_BUS_ACK: begin
                    bus_state_d = rfc_pkg::RFC_BUS_IDLE;
                    // only the addressed byte changes; other inputs untouched
                    if (wr_now) begin
                        cfg_d[cfg_rel[4:0]] = wb_dat_i[7:0]; // R11
                    end
                end
                default: begin
                    bus_state_d = rfc_pkg::RFC_BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        bus_state_q <= bus_state_d;
        rdata_q     <= rdata_d;
        cfg_q       <= cfg_d;
    end

    assign wb_ack_o = (bus_state_q == rfc_pkg::RFC_BUS_ACK) & bus_req;
    assign wb_dat_o = rdata_q;

    // ---------------- frequency divider, round robin over inputs ----------------
    logic [16:0] rem_shift;
    logic        rem_ge;

    assign rem_shift = {rem_q[15:0], dvd_q[47]};
    assign rem_ge    = (rem_shift >= {1'b0, den_q});

    always_comb begin
        div_state_d = div_state_q;
        div_ref_d   = div_ref_q;
        div_cnt_d   = div_cnt_q;
        dvd_d       = dvd_q;
        rem_d       = rem_q;
        den_d       = den_q;
        quo_d       = quo_q;
        freq_d      = freq_q;
        valid_d     = valid_q;
        changed_d   = changed_q;
        for (int r = 0; r < NUM_REFS; r++) begin
            flags_d[r] = {halving_enable_i[r], dzero[r], fec[r], sup[r]}; // R10
        end
        if (rst_i) begin
            div_state_d = rfc_pkg::RFC_DIV_PICK;
            div_ref_d   = 2'b00;
            div_cnt_d   = 6'h00;
            dvd_d       = 48'h0000_0000_0000;
            rem_d       = 17'h0_0000;
            den_d       = 16'h0000;
            quo_d       = 48'h0000_0000_0000;
            valid_d     = '0;
            changed_d   = '1;
            for (int r = 0; r < NUM_REFS; r++) begin
                freq_d[r]  = 32'h0000_0000;
                flags_d[r] = 4'h0;
            end
        end else begin
            case (div_state_q)
                rfc_pkg::RFC_DIV_PICK: begin
                    // snapshot the chosen input; a later write marks it stale
                    dvd_d                = prod[div_ref_q]; // R2
                    den_d                = nr[div_ref_q];
                    rem_d                = 17'h0_0000;
                    quo_d                = 48'h0000_0000_0000;
                    div_cnt_d            = 6'h00;
                    changed_d[div_ref_q] = 1'b0;
                    if (dzero[div_ref_q]) begin
                        quo_d       = '1;
                        div_state_d = rfc_pkg::RFC_DIV_STORE;
                    end else begin
                        div_state_d = rfc_pkg::RFC_DIV_RUN;
                    end
                end
                rfc_pkg::RFC_DIV_RUN: begin
                    dvd_d     = {dvd_q[46:0], 1'b0};
                    quo_d     = {quo_q[46:0], rem_ge};
                    rem_d     = rem_ge ? (rem_shift - {1'b0, den_q}) : rem_shift;
                    div_cnt_d = div_cnt_q + 6'h01;
                    if (div_cnt_q == rfc_pkg::DIV_STEPS - 6'h01) begin
                        div_state_d = rfc_pkg::RFC_DIV_STORE;
                    end
                end
                rfc_pkg::RFC_DIV_STORE: begin
                    freq_d[div_ref_q]  = (quo_q[47:32] != 16'h0000)
                                         ? rfc_pkg::FREQ_SATURATED : quo_q[31:0];
                    valid_d[div_ref_q] = ~changed_q[div_ref_q];
                    div_state_d        = rfc_pkg::RFC_DIV_PICK;
                    if (div_ref_q == 2'(NUM_REFS - 1)) begin
                        div_ref_d = 2'b00;
                    end else begin
                        div_ref_d = div_ref_q + 2'b01;
                    end
                end
                default: begin
                    div_state_d = rfc_pkg::RFC_DIV_PICK;
                end
            endcase
            // a write wins over the clear at snapshot time
            if (wr_now) begin
                changed_d[wr_ref] = 1'b1; // R11
                valid_d[wr_ref]   = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        div_state_q <= div_state_d;
        div_ref_q   <= div_ref_d;
        div_cnt_q   <= div_cnt_d;
        dvd_q       <= dvd_d;
        rem_q       <= rem_d;
        den_q       <= den_d;
        quo_q       <= quo_d;
        freq_q      <= freq_d;
        valid_q     <= valid_d;
        changed_q   <= changed_d;
        flags_q     <= flags_d;
    end

endmodule

//--- sim/rfc_top_monitor.sv
// rfc_top_monitor: port assertions for rfc_top
// assumes the one-cycle wishbone answer and four inputs
`timescale 1ns/1ps
module rfc_top_monitor #(
    parameter int NUM_REFS = 4
) (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic                   wb_we_i,
    input wire logic [8:0]             wb_adr_i,
    input wire logic [3:0]             wb_sel_i,
    input wire logic [31:0]            wb_dat_i,
    input wire logic [31:0]            wb_dat_o,
    input wire logic                   wb_ack_o,
    input wire logic [NUM_REFS-1:0]    halving_enable_i,
    input wire logic [NUM_REFS*16-1:0] base_rate_value_o,
    input wire logic [NUM_REFS*16-1:0] base_rate_multiplier_o,
    input wire logic [NUM_REFS*16-1:0] fec_numerator_o,
    input wire logic [NUM_REFS*16-1:0] fec_denominator_o,
    input wire logic [NUM_REFS*32-1:0] ref_frequency_o,
    input wire logic [NUM_REFS-1:0]    frequency_valid_o,
    input wire logic [NUM_REFS-1:0]    rate_supported_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       wr_ok;
    logic [6:0] idx;
    logic [7:0] wr_byte;
    assign wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
    assign idx = wb_adr_i[8:2];
    assign wr_byte = wb_dat_i[7:0];
    property p_ack_next; $rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_rd_upper; wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
    property p_dat_hold; !wb_stb_i |=> $stable(wb_dat_o); endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data changed when idle");
    property p_rst_vals;
        $fell(rst_i) |-> base_rate_value_o == {NUM_REFS{16'h9C40}}
            && fec_numerator_o == {NUM_REFS{16'h0001}}
            && fec_denominator_o == {NUM_REFS{16'h0001}}
            && base_rate_multiplier_o[63:16] == {3{16'h01E6}};
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("wrong value after reset");
    property p_wr_base; wr_ok && idx == 7'h18 |=> base_rate_value_o[31:24] == $past(wr_byte);
    endproperty
    a_wr_base: assert property (p_wr_base) else $error("base high byte not stored");
    property p_wr_den; wr_ok && idx == 7'h26 |=> fec_denominator_o[47:40] == $past(wr_byte);
    endproperty
    a_wr_den: assert property (p_wr_den) else $error("denominator byte misplaced");
    property p_wr_mul;
        wr_ok && idx == 7'h23 |=> base_rate_multiplier_o[39:32] == $past(wr_byte);
    endproperty
    a_wr_mul: assert property (p_wr_mul) else $error("multiplier low byte misplaced");
    property p_no_cross;
        wr_ok && idx inside {[7'h18:7'h1F]}
            |=> $stable(base_rate_value_o[63:32]) && $stable(fec_numerator_o[63:32]);
    endproperty
    a_no_cross: assert property (p_no_cross) else $error("write disturbed another input");
    c_write: cover property (wr_ok);
    c_read: cover property (wb_ack_o && !wb_we_i);
    c_valid: cover property (frequency_valid_o[2]);
endmodule
bind rfc_top rfc_top_monitor #(.NUM_REFS(NUM_REFS)) mon_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .halving_enable_i(halving_enable_i),
    .base_rate_value_o(base_rate_value_o), .base_rate_multiplier_o(base_rate_multiplier_o),
    .fec_numerator_o(fec_numerator_o), .fec_denominator_o(fec_denominator_o),
    .ref_frequency_o(ref_frequency_o), .frequency_valid_o(frequency_valid_o),
    .rate_supported_o(rate_supported_o));

//--- sim/tb.sv
// tb: register-level test of rfc_top through its wishbone slave
// assumes one byte per word index and big-endian multi-byte fields
`timescale 1ns/1ps
module tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [8:0]  wb_adr_i = 9'h000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  halving_enable_i = 4'h4;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [63:0] base_o, mult_o, num_o, den_o;
    logic [127:0] freq_o;
    logic [3:0]  valid_o, supp_o;
    int          miscompares = 0;
    int          n_checks = 0;
    always #10 clk_i = ~clk_i;
    rfc_top #(.NUM_REFS(4)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .halving_enable_i(halving_enable_i),
        .base_rate_value_o(base_o), .base_rate_multiplier_o(mult_o),
        .fec_numerator_o(num_o), .fec_denominator_o(den_o), .ref_frequency_o(freq_o),
        .frequency_valid_o(valid_o), .rate_supported_o(supp_o));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one classic cycle; the request is held until ack is sampled
    task automatic xfer(input logic we, input logic [6:0] idx, input logic [7:0] wd,
                        input logic s0, output logic [7:0] rd);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= {3'b000, s0};
        wb_dat_i <= {24'h0, wd};
        for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++)
            @(posedge clk_i);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n == 50) begin
            chk("ack timeout", 32'h1, 32'h0);
            tally_and_finish();
        end
    endtask
    task automatic wrn(input logic [6:0] idx, input int nb, input logic [31:0] v);
        logic [7:0] d;
        for (int i = 0; i < nb; i++)
            xfer(1'b1, idx + 7'(i), v[8*(nb-1-i) +: 8], 1'b1, d);
    endtask
    task automatic rdn(input string nm, input logic [6:0] idx, input int nb,
                       input logic [31:0] e);
        logic [7:0]  d;
        logic [31:0] a;
        a = 32'h0;
        for (int i = 0; i < nb; i++) begin
            xfer(1'b0, idx + 7'(i), 8'h00, 1'b1, d);
            a = {a[23:0], d};
        end
        chk(nm, e, a);
    endtask
    function automatic logic [31:0] fexp(input logic [15:0] b, k, m, d);
        logic [63:0] p;
        p = 64'(b) * 64'(k) * 64'(m);
        if (d == 16'h0)
            return 32'hFFFF_FFFF;
        p = p / 64'(d);
        return (p > 64'hFFFF_FFFF) ? 32'hFFFF_FFFF : p[31:0];
    endfunction
    task automatic freq_chk(input int r, input logic [31:0] e);
        int n;
        @(negedge clk_i);
        for (n = 0; n < 1000 && valid_o[r] !== 1'b1; n++)
            @(negedge clk_i);
        if (n == 1000) begin
            chk("valid timeout", 32'h1, 32'h0);
            tally_and_finish();
        end else begin
            chk("frequency", e, freq_o[r*32 +: 32]);
        end
    endtask
    initial begin
        logic [7:0] d;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int r = 0; r < 4; r++) begin
            rdn("base", 7'h10 + 7'(8*r), 2, 32'h9C40);
            rdn("multiplier", 7'h12 + 7'(8*r), 2, r == 0 ? 32'h0F30 : 32'h01E6);
            rdn("ratio", 7'h14 + 7'(8*r), 4, 32'h0001_0001);
        end
        freq_chk(1, fexp(16'h9C40, 16'h01E6, 16'h1, 16'h1));
        // ordinary input: base times multiplier
        wrn(7'h18, 2, 32'h1F40);
        wrn(7'h1A, 2, 32'h0100);
        @(negedge clk_i);
        chk("base1", 32'h1F40, 32'(base_o[31:16]));
        chk("valid1 stale", 32'h0, 32'(valid_o[1]));
        chk("mult1", 32'h0100, 32'(mult_o[31:16]));
        chk("supported1", 32'h1, 32'(supp_o[1]));
        chk("base3", 32'h9C40, 32'(base_o[63:48]));
        freq_chk(1, fexp(16'h1F40, 16'h0100, 16'h1, 16'h1));
        rdn("freq1 reg", 7'h48, 4, 32'h001F_4000);
        // correction ratio on input two
        wrn(7'h22, 2, 32'h0F30);
        wrn(7'h24, 4, 32'h00FF_00ED);
        @(negedge clk_i);
        chk("num2", 32'h00FF, 32'(num_o[47:32]));
        chk("den2", 32'h00ED, 32'(den_o[47:32]));
        chk("num1", 32'h0001, 32'(num_o[31:16]));
        rdn("ratio2", 7'h24, 4, 32'h00FF_00ED);
        freq_chk(2, fexp(16'h9C40, 16'h0F30, 16'h00FF, 16'h00ED));
        rdn("status2", 7'h42, 1, 32'h1B);
        // unlisted rate is kept but flagged; zero denominator saturates
        wrn(7'h28, 2, 32'h1F41);
        wrn(7'h2E, 2, 32'h0000);
        @(negedge clk_i);
        chk("supported3", 32'h0, 32'(supp_o[3]));
        chk("base3 new", 32'h1F41, 32'(base_o[63:48]));
        freq_chk(3, 32'hFFFF_FFFF);
        rdn("status3", 7'h43, 1, 32'h16);
        // byte lane off, then an unmapped place
        xfer(1'b1, 7'h14, 8'h55, 1'b0, d);
        rdn("ratio0", 7'h14, 4, 32'h0001_0001);
        wrn(7'h30, 1, 32'hAA);
        rdn("unmapped", 7'h30, 1, 32'h0);
        // reset in mid-run restores defaults
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdn("base1 again", 7'h18, 2, 32'h9C40);
        rdn("ratio2 again", 7'h24, 4, 32'h0001_0001);
        tally_and_finish();
    end
endmodule
